/* File: verilog/lfr_framer.sv */
// Length field receive framer with send path, buffers and indicators
`timescale 1ns/1ps
`default_nettype none
`include "lfr_defines.svh"
module lfr_framer #(
  parameter int unsigned AW = `LFR_BUF_AW,
  parameter int unsigned FLASH_CYC = `LFR_FLASH_CYC,
  parameter int unsigned MAX_INTERVAL_CYC = `LFR_MAX_INTERVAL_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Host side
  input wire logic i_addressed,
  input wire logic i_configured,
  input wire logic i_send_message_request,
  input wire logic [AW:0] i_send_len,
  input wire logic i_send_wr,
  input wire logic [7:0] i_send_data,
  input wire logic i_receive_message_request,
  input wire logic i_receive_buffer_clear,
  input wire logic [AW-1:0] i_rx_rd_addr,
  output logic [7:0] o_rx_rd_data,
  output logic [AW:0] o_rx_len,
  output logic o_send_busy,
  output logic o_send_done,
  output logic o_rx_ready,
  output logic o_rx_overflow,
  // Configuration
  input wire logic [7:0] i_start_char,
  input wire logic i_start_any,
  input wire logic i_len_en,
  input wire logic [AW:0] i_len_pos,
  input wire logic [1:0] i_len_size,
  input wire logic [7:0] i_len_m,
  input wire logic i_maxlen_en,
  input wire logic [AW:0] i_maxlen,
  input wire logic i_gap_en,
  input wire logic [15:0] i_gap_bits,
  input wire logic [15:0] i_bit_cycles,
  // Character link to the serial port
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  output logic o_tx_valid,
  output logic [7:0] o_tx_char,
  input wire logic i_tx_ready,
  input wire logic i_tx_shifting,
  input wire logic i_rx_line_active,
  // Modem control
  input wire logic i_modem_signal_read,
  input wire logic [1:0] i_modem_in_pins,
  output logic [1:0] o_modem_in,
  input wire logic i_modem_signal_write,
  input wire logic [1:0] i_modem_out_val,
  output logic [1:0] o_modem_out_pins,
  // Indicators
  output logic o_led_red,
  output logic o_led_green,
  output logic o_led_tx,
  output logic o_led_rx
);
  localparam int unsigned DEPTH = 1 << AW;

  typedef struct packed {
    lfr_pkg::lfr_rx_state_t rs;
    logic [AW:0] rcnt;
    logic [31:0] lval;
    logic [AW:0] lbytes;
    logic [32:0] remain;
    logic rx_ready;
    logic rx_ovf;
    logic [AW:0] rx_len;
    logic [7:0] rd_data;
    logic [35:0] gap_cnt;
    logic tx_act;
    logic [AW:0] tx_idx;
    logic [AW:0] tx_len;
    logic [AW:0] tx_fill;
    logic tx_done;
    logic [7:0] tx_char;
    logic tx_valid;
    logic [1:0] m_in;
    logic [1:0] m_out;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic led_tx;
    logic led_rx;
  } lfr_st_t;
  lfr_st_t st_r, st_nxt;
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];

  lfr_req_if snd_if();
  lfr_req_if rcv_if();
  assign snd_if.level = i_send_message_request;
  assign rcv_if.level = i_receive_message_request;

  lfr_req_edge u_snd_edge (.i_clk(i_clk), .i_rst(i_rst), .req(snd_if));
  lfr_req_edge u_rcv_edge (.i_clk(i_clk), .i_rst(i_rst), .req(rcv_if));

  lfr_diag_led #(.FLASH_CYC(FLASH_CYC)) u_diag (
    .i_clk(i_clk), .i_rst(i_rst), .i_addressed(i_addressed),
    .i_configured(i_configured), .o_red(o_led_red), .o_green(o_led_green));

  function automatic logic [AW:0] lsize_bytes(input logic [1:0] code);
    unique case (code)
      `LFR_LSIZE_2: lsize_bytes = (AW+1)'(2);
      `LFR_LSIZE_4: lsize_bytes = (AW+1)'(4);
      default: lsize_bytes = (AW+1)'(1);
    endcase
  endfunction : lsize_bytes

  // Gap limit in clock cycles, capped to the longest measurable interval
  function automatic logic [35:0] gap_limit(input logic [15:0] bits,
      input logic [15:0] bcyc);
    logic [35:0] raw;
    logic [15:0] b;
    raw = '0;
    b = (bits > 16'(`LFR_BITTIME_MAX)) ? 16'(`LFR_BITTIME_MAX) : bits; // [RULE_09]
    raw = 36'(b) * 36'(bcyc);
    gap_limit = (raw > 36'(MAX_INTERVAL_CYC)) ?
      36'(MAX_INTERVAL_CYC) : raw; // [RULE_09]
  endfunction : gap_limit

  logic take_char;
  logic hunt_hit;
  logic in_len;
  logic len_last;
  logic end_len;
  logic end_max;
  logic end_gap;
  logic [AW:0] pos;
  logic [31:0] lval_new;

  always_comb begin
    st_nxt = st_r;
    pos = st_r.rcnt + (AW+1)'(1);
    take_char = i_rx_valid && (st_r.rs == lfr_pkg::LFR_BODY);
    hunt_hit = i_rx_valid && (st_r.rs == lfr_pkg::LFR_HUNT) &&
      (i_start_any || i_rx_char == i_start_char);
    // Length bytes occupy positions n .. n+size-1
    in_len = i_len_en && (pos >= i_len_pos) &&
      (pos < i_len_pos + lsize_bytes(i_len_size)); // [RULE_01] [RULE_02]
    len_last = in_len && (pos == i_len_pos + lsize_bytes(i_len_size)
      - (AW+1)'(1));
    lval_new = {st_r.lval[23:0], i_rx_char}; // [RULE_18]
    end_len = 1'b0;
    end_max = 1'b0;
    end_gap = 1'b0;

    st_nxt.pin_s1 = i_modem_in_pins;
    st_nxt.pin_s2 = st_r.pin_s1;
    if (i_modem_signal_read) st_nxt.m_in = st_r.pin_s2; // [RULE_13]
    if (i_modem_signal_write) st_nxt.m_out = i_modem_out_val; // [RULE_13]

    // Receive side
    unique case (st_r.rs)
      lfr_pkg::LFR_IDLE: begin
        if (rcv_if.start) begin
          st_nxt.rs = lfr_pkg::LFR_HUNT;
          st_nxt.rx_ready = 1'b0;
        end
      end
      lfr_pkg::LFR_HUNT: begin
        if (hunt_hit) begin
          st_nxt.rs = lfr_pkg::LFR_BODY; // [RULE_14]
          st_nxt.rcnt = (AW+1)'(1);
          st_nxt.remain = '1;
          st_nxt.gap_cnt = '0;
          st_nxt.lval = '0;
          st_nxt.rx_ovf = 1'b0;
          if (i_len_en && i_len_pos == (AW+1)'(1)) begin
            st_nxt.lval = {24'h0, i_rx_char};
            if (lsize_bytes(i_len_size) == (AW+1)'(1))
              st_nxt.remain = 33'(i_rx_char) + 33'(i_len_m);
          end
        end
      end
      lfr_pkg::LFR_BODY: begin
        st_nxt.gap_cnt = take_char ? '0 : st_r.gap_cnt + 36'h1;
        end_gap = i_gap_en && !take_char &&
          (st_r.gap_cnt >= gap_limit(i_gap_bits, i_bit_cycles));
        if (take_char) begin
          if (st_r.rcnt == (AW+1)'(DEPTH)) st_nxt.rx_ovf = 1'b1; // [RULE_05]
          else st_nxt.rcnt = pos;
          if (in_len) st_nxt.lval = lval_new;
          if (len_last) begin
            // Counted bytes start right after the last length byte
            st_nxt.remain = 33'(lval_new) + 33'(i_len_m); // [RULE_03] [RULE_04]
            end_len = (lval_new == '0) && (i_len_m == '0);
          end else if (!in_len && st_r.remain != '1) begin
            st_nxt.remain = st_r.remain - 33'h1;
            end_len = (st_r.remain == 33'h1); // [RULE_03]
          end
          end_max = i_maxlen_en && (pos >= i_maxlen);
        end
        // Whichever enabled condition fires first closes the frame
        if (end_len || end_max || end_gap || st_nxt.rx_ovf) begin // [RULE_17]
          st_nxt.rs = lfr_pkg::LFR_DONE;
          st_nxt.rx_len = st_nxt.rcnt;
        end
      end
      lfr_pkg::LFR_DONE: begin
        st_nxt.rx_ready = 1'b1; // [RULE_15]
        st_nxt.rs = lfr_pkg::LFR_IDLE;
      end
      default: st_nxt.rs = lfr_pkg::LFR_IDLE;
    endcase
    if (i_receive_buffer_clear) begin // [RULE_13]
      st_nxt.rs = lfr_pkg::LFR_IDLE;
      st_nxt.rx_ready = 1'b0;
      st_nxt.rx_len = '0;
      st_nxt.rcnt = '0;
    end
    st_nxt.rd_data = rx_mem[i_rx_rd_addr];

    // Send side runs independently of reception
    st_nxt.tx_done = 1'b0;
    if (!st_r.tx_act && i_send_wr && st_r.tx_fill != (AW+1)'(DEPTH))
      st_nxt.tx_fill = st_r.tx_fill + (AW+1)'(1); // [RULE_05]
    if (!st_r.tx_act && snd_if.start) begin // [RULE_06] [RULE_07]
      st_nxt.tx_act = (i_send_len != '0);
      st_nxt.tx_done = (i_send_len == '0);
      st_nxt.tx_len = (i_send_len > (AW+1)'(DEPTH)) ?
        (AW+1)'(DEPTH) : i_send_len;
      st_nxt.tx_idx = '0;
    end
    if (st_r.tx_act) begin
      if (!st_r.tx_valid) begin
        st_nxt.tx_char = tx_mem[st_r.tx_idx[AW-1:0]];
        st_nxt.tx_valid = 1'b1;
      end else if (i_tx_ready) begin
        st_nxt.tx_valid = 1'b0;
        st_nxt.tx_idx = st_r.tx_idx + (AW+1)'(1);
        if (st_r.tx_idx + (AW+1)'(1) == st_r.tx_len) begin
          st_nxt.tx_act = 1'b0;
          st_nxt.tx_done = 1'b1;
          st_nxt.tx_fill = '0;
        end
      end
    end
    st_nxt.led_tx = i_tx_shifting; // [RULE_11]
    st_nxt.led_rx = i_rx_line_active; // [RULE_12]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Memories are written outside the state struct; addresses are in range
  always_ff @(posedge i_clk) begin
    // The start character is the first byte of the stored message
    if (hunt_hit) rx_mem[0] <= i_rx_char; // [RULE_15]
    if (take_char && st_r.rcnt != (AW+1)'(DEPTH))
      rx_mem[st_r.rcnt[AW-1:0]] <= i_rx_char;
    if (!st_r.tx_act && i_send_wr && st_r.tx_fill != (AW+1)'(DEPTH))
      tx_mem[st_r.tx_fill[AW-1:0]] <= i_send_data;
  end

  assign o_rx_rd_data = st_r.rd_data;
  assign o_rx_len = st_r.rx_len;
  assign o_rx_ready = st_r.rx_ready;
  assign o_rx_overflow = st_r.rx_ovf;
  assign o_send_busy = st_r.tx_act;
  assign o_send_done = st_r.tx_done;
  assign o_tx_valid = st_r.tx_valid;
  assign o_tx_char = st_r.tx_char;
  assign o_modem_in = st_r.m_in;
  assign o_modem_out_pins = st_r.m_out;
  assign o_led_tx = st_r.led_tx;
  assign o_led_rx = st_r.led_rx;

  sequence s_hunt_match;
    st_r.rs == lfr_pkg::LFR_HUNT && i_rx_valid && !i_receive_buffer_clear &&
      (i_start_any || i_rx_char == i_start_char);
  endsequence

  a_start_needed: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.rs == lfr_pkg::LFR_HUNT && !i_rx_valid && !i_receive_buffer_clear
    |=> st_r.rs == lfr_pkg::LFR_HUNT) else $error("body without start"); // [RULE_14]
  a_start_enter: assert property (@(posedge i_clk) disable iff (i_rst)
    s_hunt_match |=> st_r.rs == lfr_pkg::LFR_BODY && st_r.rcnt == 1)
    else $error("start char missed"); // [RULE_14]
  a_ready_after: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_rx_ready) |-> $past(st_r.rs) == lfr_pkg::LFR_DONE)
    else $error("ready before end"); // [RULE_15]
  a_len_end: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.rs == lfr_pkg::LFR_BODY && take_char && !in_len &&
    st_r.remain == 33'h1 && !i_receive_buffer_clear
    |=> st_r.rs == lfr_pkg::LFR_DONE)
    else $error("length end missed"); // [RULE_03]
  a_rx_cap: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.rcnt <= (AW+1)'(DEPTH)) else $error("rx over 1024"); // [RULE_05]
  a_tx_idle_start: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_r.tx_act && !snd_if.start |=> !st_r.tx_act)
    else $error("send without edge"); // [RULE_07]
  a_led_tx_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    i_tx_shifting |=> o_led_tx) else $error("tx led dark"); // [RULE_11]
  a_led_rx_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rx_line_active |=> !o_led_rx) else $error("rx led lit"); // [RULE_12]
  a_clear_rx: assert property (@(posedge i_clk) disable iff (i_rst)
    i_receive_buffer_clear |=> !o_rx_ready && o_rx_len == 0)
    else $error("clear ignored"); // [RULE_13]
endmodule : lfr_framer
`default_nettype wire

/* File: include/lfr_defines.svh */
// Constants for the length field serial receive framer
// What this block does
// RULE_01: Length field at configurable 1-based position n
// RULE_02: Length field is one, two or four bytes
// RULE_03: Expect length plus m uncounted characters, end
// RULE_04: Counted bytes follow the last length byte
// RULE_05: Each buffer holds at most 1024 bytes
// RULE_06: Send and receive run concurrently, host polls
// RULE_07: Operations start on request rising edge only
// RULE_08: Request must go low before next start
// RULE_09: Bit time values to 64000, capped 8 s
// RULE_10: Diag LED red flash, green flash, then steady
// RULE_11: Transmit LED lit while sending
// RULE_12: Receive LED lit while receiving
// RULE_13: Receive buffer clear and modem signal commands
// RULE_14: Reception begins only at start condition
// RULE_15: Completion reported only after end condition
// RULE_16: Responder host polls twice per master timeout
// RULE_17: Any enabled end condition ends the message
// RULE_18: Multi-byte length is unsigned, MSB first
`ifndef LFR_DEFINES_SVH
`define LFR_DEFINES_SVH
`define LFR_BUF_BYTES 1024
`define LFR_BUF_AW 10
`define LFR_CLK_NS 4
`define LFR_BITTIME_MAX 64000
`define LFR_MAX_INTERVAL_S 8
// Divide first so the product stays inside a 32-bit integer
`define LFR_MAX_INTERVAL_CYC (`LFR_MAX_INTERVAL_S * (1000000000 / `LFR_CLK_NS))
`define LFR_FLASH_MS 250
`define LFR_FLASH_CYC (`LFR_FLASH_MS * 1000000 / `LFR_CLK_NS)
`define LFR_LSIZE_1 2'h0
`define LFR_LSIZE_2 2'h1
`define LFR_LSIZE_4 2'h2
`endif

/* File: include/lfr_pkg.sv */
// Types shared by the framer modules
package lfr_pkg;
  typedef enum logic [1:0] {
    LFR_IDLE, LFR_HUNT, LFR_BODY, LFR_DONE
  } lfr_rx_state_t;
  typedef enum logic [1:0] {
    LFR_DIAG_RED, LFR_DIAG_FLASH_G, LFR_DIAG_GREEN
  } lfr_diag_t;
endpackage : lfr_pkg

/* File: include/lfr_req_if.sv */
// Request edge carrier between the top and the edge detector
`timescale 1ns/1ps
`default_nettype none
interface lfr_req_if;
  logic level;
  logic start;
  modport det (input level, output start);
  modport use_side (output level, input start);
endinterface : lfr_req_if
`default_nettype wire

/* File: verilog/lfr_req_edge.sv */
// Rising edge request detector with re-arm on low
`timescale 1ns/1ps
`default_nettype none
module lfr_req_edge (
  input wire logic i_clk,
  input wire logic i_rst,
  lfr_req_if.det req
);
  typedef struct packed {
    logic armed;
  } lfr_edge_st_t;
  lfr_edge_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    // History resets only when the request is seen low
    if (!req.level) st_nxt.armed = 1'b1; // [RULE_08]
    else st_nxt.armed = 1'b0;
  end

  assign req.start = req.level && st_r.armed; // [RULE_07]

  always_ff @(posedge i_clk) begin
    if (i_rst) st_r <= '{armed: 1'b0};
    else st_r <= st_nxt;
  end

  a_no_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    req.start |=> !req.start) else $error("start repeated"); // [RULE_08]
endmodule : lfr_req_edge
`default_nettype wire

/* File: verilog/lfr_diag_led.sv */
// Diagnostic indicator sequencer
`timescale 1ns/1ps
`default_nettype none
`include "lfr_defines.svh"
module lfr_diag_led #(
  parameter int unsigned FLASH_CYC = `LFR_FLASH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_addressed,
  input wire logic i_configured,
  output logic o_red,
  output logic o_green
);
  typedef struct packed {
    lfr_pkg::lfr_diag_t mode;
    logic [26:0] cnt;
    logic phase;
    logic red;
    logic green;
  } lfr_diag_st_t;
  lfr_diag_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt >= 27'(FLASH_CYC - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.phase = !st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + 27'h1;
    end
    unique case (st_r.mode)
      lfr_pkg::LFR_DIAG_RED:
        if (i_addressed) st_nxt.mode = lfr_pkg::LFR_DIAG_FLASH_G;
      lfr_pkg::LFR_DIAG_FLASH_G:
        if (i_configured) st_nxt.mode = lfr_pkg::LFR_DIAG_GREEN;
      lfr_pkg::LFR_DIAG_GREEN: ;
    endcase
    st_nxt.red = (st_nxt.mode == lfr_pkg::LFR_DIAG_RED) && st_nxt.phase; // [RULE_10]
    st_nxt.green = (st_nxt.mode == lfr_pkg::LFR_DIAG_GREEN) ||
      ((st_nxt.mode == lfr_pkg::LFR_DIAG_FLASH_G) && st_nxt.phase); // [RULE_10]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) st_r <= '{mode: lfr_pkg::LFR_DIAG_RED, cnt: 27'h0,
      phase: 1'b1, red: 1'b0, green: 1'b0};
    else st_r <= st_nxt;
  end

  assign o_red = st_r.red;
  assign o_green = st_r.green;

  a_green_steady: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.mode == lfr_pkg::LFR_DIAG_GREEN |=> o_green && !o_red)
    else $error("green not steady"); // [RULE_10]
endmodule : lfr_diag_led
`default_nettype wire

/* File: verif/lfr_serial_model.sv */
// Serial port side model: takes transmit characters, feeds received ones
`timescale 1ns/1ps
`default_nettype none
module lfr_serial_model (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_char,
  output logic o_tx_ready,
  output logic o_tx_shifting,
  output logic o_rx_valid,
  output logic [7:0] o_rx_char,
  output logic o_rx_active
);
  logic [7:0] sent[$];
  initial begin
    o_tx_ready = 1'b0;
    o_tx_shifting = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_rx_active = 1'b0;
  end
  // Random stalls keep a held character visible over several cycles
  always @(negedge i_clk) begin
    o_tx_ready = i_tx_valid && ($urandom_range(2) == 0);
    o_tx_shifting = i_tx_valid;
  end
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) sent.push_back(i_tx_char);
  end
  // Idle line shows the inverse, so stale data never passes for new
  task put_char(input logic [7:0] c);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_char = c;
    o_rx_active = 1'b1;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_char = ~c;
    o_rx_active = 1'b0;
  endtask : put_char
endmodule : lfr_serial_model
`default_nettype wire

/* File: verif/lfr_framer_tb.sv */
// Self-checking bench for the length field receive framer
`timescale 1ns/1ps
`default_nettype none
module lfr_framer_tb;
  logic clk, rst, addr_d, cfg_d, sreq, swr, rreq, rclr, mlen_en;
  logic mrd, mwr, tx_valid, tx_ready, sh, rx_valid, rx_act;
  logic busy, sdone, rx_ready, rx_ovf, led_r, led_g, led_tx, led_rx;
  logic sh_q, act_q;
  logic sany, len_en, gap_en;
  logic [15:0] gbits, bcyc;
  localparam int GAP_CAP = 100;
  logic [10:0] slen, lpos, mlen, rx_len;
  logic [9:0] rd_addr;
  logic [7:0] sdata, lm, rd_data, sc, tx_char, rx_char;
  logic [1:0] lsize, mout, m_pins, min_p, m_in;
  logic [7:0] msg[$];
  int failures, comparisons, cycles;
  int unsigned seed;
  lfr_framer #(.FLASH_CYC(4), .MAX_INTERVAL_CYC(GAP_CAP)) i_lfr_framer (
    .i_clk(clk), .i_rst(rst), .i_addressed(addr_d), .i_configured(cfg_d),
    .i_send_message_request(sreq), .i_send_len(slen), .i_send_wr(swr),
    .i_send_data(sdata), .i_receive_message_request(rreq),
    .i_receive_buffer_clear(rclr), .i_rx_rd_addr(rd_addr),
    .o_rx_rd_data(rd_data), .o_rx_len(rx_len), .o_send_busy(busy),
    .o_send_done(sdone), .o_rx_ready(rx_ready), .o_rx_overflow(rx_ovf),
    .i_start_char(sc), .i_start_any(sany), .i_len_en(len_en),
    .i_len_pos(lpos), .i_len_size(lsize), .i_len_m(lm),
    .i_maxlen_en(mlen_en), .i_maxlen(mlen), .i_gap_en(gap_en),
    .i_gap_bits(gbits), .i_bit_cycles(bcyc),
    .i_rx_valid(rx_valid), .i_rx_char(rx_char), .o_tx_valid(tx_valid),
    .o_tx_char(tx_char), .i_tx_ready(tx_ready), .i_tx_shifting(sh),
    .i_rx_line_active(rx_act), .i_modem_signal_read(mrd),
    .i_modem_in_pins(min_p), .o_modem_in(m_in),
    .i_modem_signal_write(mwr), .i_modem_out_val(mout),
    .o_modem_out_pins(m_pins), .o_led_red(led_r), .o_led_green(led_g),
    .o_led_tx(led_tx), .o_led_rx(led_rx));
  lfr_serial_model i_lfr_serial_model (
    .i_clk(clk), .i_tx_valid(tx_valid), .i_tx_char(tx_char),
    .o_tx_ready(tx_ready), .o_tx_shifting(sh), .o_rx_valid(rx_valid),
    .o_rx_char(rx_char), .o_rx_active(rx_act));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // Expected gap in cycles: bit times by cycles per bit, capped
  function automatic int gap_wait(input int bits, input int bc, input int cap);
    return (bits * bc > cap) ? cap : bits * bc;
  endfunction : gap_wait
  task conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Watchdog: far above the longest expected run
  always @(posedge clk) begin
    sh_q <= sh;
    act_q <= rx_act;
    cycles++;
    if (cycles > 30000) begin
      failures++;
      conclude();
    end
  end
  always @(negedge clk) begin
    if (!rst) begin
      check("led tx", sh_q, led_tx);
      check("led rx", act_q, led_rx);
    end
  end
  task arm;
    @(negedge clk) rreq = 1'b0;
    @(negedge clk) rreq = 1'b1;
    @(negedge clk);
  endtask : arm
  task diag(input logic [3:0] e);
    int r, g;
    r = 0;
    g = 0;
    repeat (16) begin
      @(negedge clk);
      r += (led_r === 1'b1);
      g += (led_g === 1'b1);
    end
    check("diag led", e, {r == 0, r == 16, g == 0, g == 16});
  endtask : diag
  task rx_frame(input int n, input int sz, input int ln, input int m,
                input bit cut);
    int tot, exp;
    logic [7:0] b;
    tot = n + sz - 1 + ln + m;
    exp = (cut && tot > n + sz) ? tot - 1 : tot;
    mlen_en = (exp != tot);
    mlen = exp[10:0];
    lpos = n[10:0];
    lm = m[7:0];
    lsize = (sz == 1) ? 2'h0 : (sz == 2) ? 2'h1 : 2'h2;
    arm();
    msg.delete();
    i_lfr_serial_model.put_char(sc ^ 8'h80);
    for (int i = 1; i <= exp; i++) begin
      b = (i == 1) ? sc : 8'($urandom);
      if (i >= n && i < n + sz) b = 8'(ln >> (8 * (n + sz - 1 - i)));
      if (i == exp) check("early ready", 0, rx_ready);
      msg.push_back(b);
      i_lfr_serial_model.put_char(b);
    end
    for (int t = 0; t < 8 && rx_ready !== 1'b1; t++) @(negedge clk);
    check("rx ready", 1, rx_ready);
    check("rx len", exp, rx_len);
    check("overflow", 0, rx_ovf);
    foreach (msg[i]) begin
      rd_addr = i[9:0];
      @(negedge clk);
      check("rx byte", msg[i], rd_data);
    end
  endtask : rx_frame
  task send_msg(input int k);
    logic [7:0] q[$];
    i_lfr_serial_model.sent.delete();
    q.delete();
    for (int i = 0; i < k; i++) begin
      @(negedge clk);
      swr = 1'b1;
      sdata = 8'($urandom);
      q.push_back(sdata);
    end
    @(negedge clk);
    swr = 1'b0;
    slen = k[10:0];
    sreq = 1'b1;
    @(negedge clk);
    check("send busy", 1, busy);
    for (int t = 0; t < 400 && sdone !== 1'b1; t++) @(negedge clk);
    check("send done", 1, sdone);
    check("send idle", 0, busy);
    check("sent count", k, i_lfr_serial_model.sent.size());
    foreach (q[i]) check("tx char", q[i], i_lfr_serial_model.sent[i]);
    sreq = 1'b0;
  endtask : send_msg
  initial begin
    {rst, rreq} = 2'h3;
    {addr_d, cfg_d, sreq, swr, rclr, mlen_en, mrd, mwr} = 8'h00;
    {sany, len_en, gap_en, gbits, bcyc} = {3'h2, 16'h000c, 16'h0010};
    {slen, mlen, rd_addr, sdata, lm, lsize, mout, min_p} = '0;
    lpos = 11'h002;
    sc = 8'h02;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    seed = $urandom(32'h4ac0);
    diag(4'h2);
    addr_d = 1'b1;
    repeat (3) @(negedge clk);
    diag(4'h8);
    cfg_d = 1'b1;
    repeat (3) @(negedge clk);
    diag(4'h9);
    $display("test diag done");
    // Request high since reset was never seen low, so nothing is armed
    foreach (msg[i]) msg.delete();
    i_lfr_serial_model.put_char(sc);
    i_lfr_serial_model.put_char(8'h00);
    repeat (4) @(negedge clk);
    check("level start", 0, rx_ready);
    $display("test level done");
    rx_frame(2, 1, 12, 0, 0);
    rx_frame(3, 1, 6, 3, 0);
    rx_frame(4, 2, 0, 0, 0);
    // Length in the start character itself: value equals the start code
    sc = 8'h03;
    rx_frame(1, 1, 3, 1, 0);
    for (int k = 0; k < 9; k++) begin
      sc = 8'($urandom);
      rx_frame(2 + $urandom_range(2), (k % 3 == 2) ? 4 : k % 3 + 1,
               $urandom_range(12), $urandom_range(3), k % 4 == 3);
    end
    $display("test frames done");
    fork
      send_msg(2 + $urandom_range(5));
      rx_frame(2, 2, 5, 1, 0);
    join
    send_msg(1);
    $display("test concurrent done");
    @(negedge clk) rclr = 1'b1;
    @(negedge clk) rclr = 1'b0;
    @(negedge clk);
    check("clear ready", 0, rx_ready);
    check("clear len", 0, rx_len);
    mout = 2'($urandom);
    min_p = ~mout;
    @(negedge clk) mwr = 1'b1;
    @(negedge clk) mwr = 1'b0;
    repeat (3) @(negedge clk);
    check("modem out", mout, m_pins);
    @(negedge clk) mrd = 1'b1;
    @(negedge clk) mrd = 1'b0;
    @(negedge clk);
    check("modem in", min_p, m_in);
    $display("test commands done");
    {lpos, lsize, lm, mlen_en} = {11'h002, 2'h1, 8'h00, 1'b0};
    arm();
    for (int i = 0; i < 1026; i++)
      i_lfr_serial_model.put_char(i == 0 ? sc : i == 1 ? 8'h08 : 8'h55);
    repeat (4) @(negedge clk);
    check("overflow", 1, rx_ovf);
    $display("test overflow done");
    // Gap end only, any character starts; the cap must shorten the wait
    {len_en, sany, gap_en} = 3'h3;
    arm();
    msg.delete();
    repeat (3) begin
      msg.push_back(8'($urandom));
      i_lfr_serial_model.put_char(msg[$]);
    end
    repeat (gap_wait(gbits, bcyc, GAP_CAP) - 10) @(negedge clk);
    check("gap early", 0, rx_ready);
    for (int t = 0; t < 20 && rx_ready !== 1'b1; t++) @(negedge clk);
    check("gap ready", 1, rx_ready);
    check("gap len", 3, rx_len);
    rd_addr = 10'h000;
    @(negedge clk);
    check("gap byte", msg[0], rd_data);
    $display("test gap done");
    conclude();
  end
endmodule : lfr_framer_tb
`default_nettype wire
